// File: rtl/mss_consts.vh
// Overview of operation
// [R1] Four select inputs form a binary code; zero picks master, 1-15 pick presets.
// [R2] Fifteen preset frequencies, 0 to 400.00 Hz in 0.01 Hz, reset to zero.
// [R3] Every input terminal is delayed by 1 to 20 units of 2 ms, default 1.
// [R4] Index gear ratio accepts 4 to 1000, default 200.
// [R5] Index angle accepts 0.0 to 360.0 degrees in 0.1 steps, default 180.0.
// [R6] Index deceleration time accepts 0.00 to 100.00 s, default zero.
// [R7] With index on, a stop holds speed until the sensor fires, then decelerates.
// [R8] Index angle is counted from the moment the proximity sensor fires.
// [R9] The user must assign one input terminal the proximity sensor function.
// [R10] Sequencer mode: 0 off, 1 one cycle, 2 continuous, 3 and 4 stepwise.
// [R11] While sequencing, speed and direction follow the programmed steps.
// [R12] The user must assign and drive active the sequencer run input.
// [R13] Outputs show sequencer running, step complete and program complete.
// [R14] One-cycle mode stops after one cycle; restart needs enable off then on.
// [R15] Continuous mode repeats until paused or switched off.
// [R16] Each step uses its own direction and its own operation time.
// [R17] Step directions come from a 15-bit word, set bit is reverse.
// [R18] A step programmed with zero time is skipped.
// [R19] A new input level is accepted only after staying stable for the interval.
// [R20] Steps advance in ascending order, moving on when the step time expires.
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH

`define MSS_CLK_HZ        100000000
`define MSS_DEB_UNIT_US   2000
`define MSS_DEB_UNIT_CYC  (`MSS_CLK_HZ / 1000000 * `MSS_DEB_UNIT_US)
`define MSS_STEP_UNIT_MS  100
`define MSS_STEP_UNIT_CYC (`MSS_CLK_HZ / 1000 * `MSS_STEP_UNIT_MS)
`define MSS_DEC_UNIT_MS   10
`define MSS_DEC_UNIT_CYC  (`MSS_CLK_HZ / 1000 * `MSS_DEC_UNIT_MS)

`define MSS_ADDR_CTRL     12'h000
`define MSS_ADDR_DEB      12'h004
`define MSS_ADDR_MASTER   12'h008
`define MSS_ADDR_DIR      12'h00C
`define MSS_ADDR_GEAR     12'h010
`define MSS_ADDR_ANGLE    12'h014
`define MSS_ADDR_IDEC     12'h018
`define MSS_ADDR_STATUS   12'h01C
`define MSS_ADDR_FREQ0    12'h040
`define MSS_ADDR_TIME0    12'h080
`define MSS_ADDR_LAST     12'h0B8

`define MSS_CTRL_IDX_BIT  8
`define MSS_MODE_OFF      3'h0
`define MSS_MODE_ONE      3'h1
`define MSS_MODE_CONT     3'h2
`define MSS_MODE_ONE_SW   3'h3
`define MSS_MODE_CONT_SW  3'h4

`define MSS_DEB_RST       5'h01
`define MSS_DEB_MIN       5'h01
`define MSS_DEB_MAX       5'h14
`define MSS_FREQ_MAX      16'h9C40
`define MSS_GEAR_RST      10'h0C8
`define MSS_GEAR_MIN      10'h004
`define MSS_GEAR_MAX      10'h3E8
`define MSS_ANGLE_RST     12'h708
`define MSS_ANGLE_MAX     12'hE10
`define MSS_IDEC_MAX      14'h2710

`define MSS_IN_SEL0       0
`define MSS_IN_SEQ_EN     4
`define MSS_IN_PAUSE      5
`define MSS_IN_PROX       6
`define MSS_IN_STOP       7
`define MSS_IN_DIR        8
`define MSS_IN_N          9

`endif

// File: rtl/mss_debounce.v
`timescale 1ns/1ps
`default_nettype none
`include "mss_consts.vh"
module mss_debounce
(
  // clock and reset
  input  wire                   pclk,
  input  wire                   presetn,
  // timing
  input  wire                   tick,
  input  wire [4:0]             units,
  // terminals
  input  wire [`MSS_IN_N-1:0]   pin_in,
  output reg  [`MSS_IN_N-1:0]   level
);

  reg [`MSS_IN_N-1:0] s1;
  reg [`MSS_IN_N-1:0] s2;
  reg [`MSS_IN_N-1:0] s3;
  reg [4:0]           cnt [0:`MSS_IN_N-1];
  integer             i;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1    <= {`MSS_IN_N{1'b0}};
      s2    <= {`MSS_IN_N{1'b0}};
      s3    <= {`MSS_IN_N{1'b0}};
      level <= {`MSS_IN_N{1'b0}};
      for (i = 0; i < `MSS_IN_N; i = i + 1)
        cnt[i] <= 5'h00;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < `MSS_IN_N; i = i + 1)
      begin
        // any disagreement or return to the old level restarts the wait
        if (s2[i] != s3[i] || s3[i] == level[i])
          cnt[i] <= 5'h00; // R19
        else if (tick)
        begin
          // one extra tick: the first tick after a change is only partial
          if (cnt[i] >= units)
          begin
            level[i] <= s3[i]; // R3
            cnt[i]   <= 5'h00;
          end
          else
            cnt[i] <= cnt[i] + 5'h01;
        end
      end
    end
  end

endmodule // mss_debounce
`default_nettype wire

// File: rtl/mss_top.v
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mss_consts.vh"
module mss_top
#(
  parameter DEB_UNIT_CYC  = `MSS_DEB_UNIT_CYC,
  parameter STEP_UNIT_CYC = `MSS_STEP_UNIT_CYC,
  parameter DEC_UNIT_CYC  = `MSS_DEC_UNIT_CYC
)
(
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // input terminals
  input  wire        speed_select_bit0,
  input  wire        speed_select_bit1,
  input  wire        speed_select_bit2,
  input  wire        speed_select_bit3,
  input  wire        seq_enable,
  input  wire        seq_pause,
  input  wire        prox_sensor,
  input  wire        stop_cmd,
  input  wire        dir_cmd_reverse,
  // speed command to the ramp engine
  output reg  [15:0] freq_cmd,
  output reg         dir_reverse,
  output reg         seq_stepwise,
  // output terminals
  output reg         seq_running,
  output reg         seq_step_done,
  output reg         seq_prog_done,
  // index positioning
  output reg         idx_hold,
  output reg         idx_start,
  output reg         idx_decel,
  output reg         idx_stopped
);

  localparam S_IDLE = 4'b0001;
  localparam S_RUN  = 4'b0010;
  localparam S_NEXT = 4'b0100;
  localparam S_DONE = 4'b1000;
  localparam I_IDLE = 4'b0001;
  localparam I_WAIT = 4'b0010;
  localparam I_DEC  = 4'b0100;
  localparam I_STOP = 4'b1000;

  // limit a written value to its legal range
  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  reg  [2:0]  mode;
  reg         idx_en;
  reg  [4:0]  deb_units;
  reg  [15:0] master_freq;
  reg  [14:0] step_dir;
  reg  [9:0]  gear;
  reg  [11:0] angle;
  reg  [13:0] idx_dec_time;
  reg  [15:0] step_freq [0:14];
  reg  [15:0] step_time [0:14];
  reg  [3:0]  sstate;
  reg  [3:0]  istate;
  reg  [3:0]  step;
  reg  [15:0] step_cnt;
  reg  [13:0] dec_cnt;
  reg         en_seen_off;
  reg  [31:0] deb_div;
  reg  [31:0] step_div;
  reg  [31:0] dec_div;
  reg         deb_tick;
  reg         step_tick;
  reg         dec_tick;
  reg         prox_d;
  reg  [31:0] rd_val;
  reg         rd_hit;
  wire [`MSS_IN_N-1:0] din;
  wire [3:0]  sel_code;
  wire        sel_freq_reg;
  wire        sel_time_reg;
  wire [3:0]  reg_idx;
  wire        wr_en;
  wire [15:0] wr_deb;
  wire [15:0] wr_gear;
  wire [15:0] wr_angle;
  wire [15:0] wr_idec;
  integer     k;

  assign sel_code     = din[`MSS_IN_SEL0+3:`MSS_IN_SEL0]; // R1
  assign sel_freq_reg = paddr[11:6] == 6'h01 && paddr[5:2] != 4'hF;
  assign sel_time_reg = paddr[11:6] == 6'h02 && paddr[5:2] != 4'hF;
  assign reg_idx      = paddr[5:2];
  assign wr_en        = psel & penable & pready & pwrite;
  // clamp over the whole low half, so large values saturate and never wrap
  assign wr_deb       = clamp(pwdata[15:0], {11'h0, `MSS_DEB_MIN},
                              {11'h0, `MSS_DEB_MAX});
  assign wr_gear      = clamp(pwdata[15:0], {6'h0, `MSS_GEAR_MIN},
                              {6'h0, `MSS_GEAR_MAX});
  assign wr_angle     = clamp(pwdata[15:0], 16'h0, {4'h0, `MSS_ANGLE_MAX});
  assign wr_idec      = clamp(pwdata[15:0], 16'h0, {2'h0, `MSS_IDEC_MAX});

  mss_debounce u_deb
  (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (deb_tick),
    .units   (deb_units),
    .pin_in  ({dir_cmd_reverse, stop_cmd, prox_sensor, seq_pause,
               seq_enable, speed_select_bit3, speed_select_bit2,
               speed_select_bit1, speed_select_bit0}),
    .level   (din)
  );

  // timebase dividers, one-cycle enables
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      deb_div   <= 32'h0;
      step_div  <= 32'h0;
      dec_div   <= 32'h0;
      deb_tick  <= 1'b0;
      step_tick <= 1'b0;
      dec_tick  <= 1'b0;
    end
    else
    begin
      deb_tick  <= deb_div == DEB_UNIT_CYC - 1;
      deb_div   <= (deb_div == DEB_UNIT_CYC - 1) ? 32'h0 : deb_div + 32'h1;
      step_tick <= step_div == STEP_UNIT_CYC - 1;
      step_div  <= (step_div == STEP_UNIT_CYC - 1) ? 32'h0
                                                  : step_div + 32'h1;
      // restarted at the trigger so decel time counts from it
      dec_tick  <= dec_div == DEC_UNIT_CYC - 1;
      dec_div   <= (dec_div == DEC_UNIT_CYC - 1 || (din[`MSS_IN_PROX] &
                   !prox_d)) ? 32'h0 : dec_div + 32'h1;
    end
  end

  // apb read mux
  always @*
  begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    if (sel_freq_reg)
      rd_val = {16'h0, step_freq[reg_idx]};
    else if (sel_time_reg)
      rd_val = {16'h0, step_time[reg_idx]};
    else
      case (paddr)
        `MSS_ADDR_CTRL:   rd_val = {23'h0, idx_en, 5'h0, mode};
        `MSS_ADDR_DEB:    rd_val = {27'h0, deb_units};
        `MSS_ADDR_MASTER: rd_val = {16'h0, master_freq};
        `MSS_ADDR_DIR:    rd_val = {17'h0, step_dir};
        `MSS_ADDR_GEAR:   rd_val = {22'h0, gear};
        `MSS_ADDR_ANGLE:  rd_val = {20'h0, angle};
        `MSS_ADDR_IDEC:   rd_val = {18'h0, idx_dec_time};
        `MSS_ADDR_STATUS: rd_val = {16'h0, istate, sstate, 4'h0, step};
        default:          rd_hit = 1'b0;
      endcase
  end

  // apb: answer registered in the cycle after setup, one wait-free access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h0;
      mode         <= `MSS_MODE_OFF;
      idx_en       <= 1'b0;
      deb_units    <= `MSS_DEB_RST;
      master_freq  <= 16'h0;
      step_dir     <= 15'h0;
      gear         <= `MSS_GEAR_RST;
      angle        <= `MSS_ANGLE_RST;
      idx_dec_time <= 14'h0;
      for (k = 0; k < 15; k = k + 1)
      begin
        step_freq[k] <= 16'h0; // R2
        step_time[k] <= 16'h0;
      end
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0;
      if (wr_en && sel_freq_reg)
        step_freq[reg_idx] <= clamp(pwdata[15:0], 16'h0,
                                    `MSS_FREQ_MAX); // R2
      if (wr_en && sel_time_reg)
        step_time[reg_idx] <= pwdata[15:0]; // R16
      if (wr_en)
        case (paddr)
          `MSS_ADDR_CTRL:
          begin
            mode   <= (pwdata[2:0] > `MSS_MODE_CONT_SW) ? `MSS_MODE_OFF
                                                          : pwdata[2:0];
            idx_en <= pwdata[`MSS_CTRL_IDX_BIT];
          end
          `MSS_ADDR_DEB:
            deb_units <= wr_deb[4:0]; // R3
          `MSS_ADDR_MASTER:
            master_freq <= clamp(pwdata[15:0], 16'h0, `MSS_FREQ_MAX);
          `MSS_ADDR_DIR:
            step_dir <= pwdata[14:0]; // R17
          `MSS_ADDR_GEAR:
            gear <= wr_gear[9:0]; // R4
          `MSS_ADDR_ANGLE:
            angle <= wr_angle[11:0]; // R5
          `MSS_ADDR_IDEC:
            idx_dec_time <= wr_idec[13:0]; // R6
          default:
            ;
        endcase
    end
  end

  // step sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sstate        <= S_IDLE;
      step          <= 4'h0;
      step_cnt      <= 16'h0;
      en_seen_off   <= 1'b1;
      seq_running   <= 1'b0;
      seq_step_done <= 1'b0;
      seq_prog_done <= 1'b0;
      seq_stepwise  <= 1'b0;
    end
    else
    begin
      seq_step_done <= 1'b0;
      seq_stepwise  <= mode == `MSS_MODE_ONE_SW ||
                       mode == `MSS_MODE_CONT_SW; // R10
      if (!din[`MSS_IN_SEQ_EN])
        en_seen_off <= 1'b1;
      if (!din[`MSS_IN_SEQ_EN] || mode == `MSS_MODE_OFF)
      begin
        sstate        <= S_IDLE; // R15
        seq_running   <= 1'b0;
        seq_prog_done <= 1'b0;
      end
      else
        case (sstate)
          S_IDLE:
            if (en_seen_off) // R12
            begin
              en_seen_off <= 1'b0;
              step        <= 4'h0;
              step_cnt    <= 16'h0;
              seq_running <= 1'b1; // R13
              sstate      <= S_RUN;
            end
          S_RUN:
            if (step_time[step] == 16'h0)
              sstate <= S_NEXT; // R18
            else if (!din[`MSS_IN_PAUSE] && step_tick) // R15
            begin
              if (step_cnt + 16'h1 >= step_time[step])
              begin
                seq_step_done <= 1'b1; // R13
                sstate        <= S_NEXT;
              end
              else
                step_cnt <= step_cnt + 16'h1;
            end
          S_NEXT:
          begin
            step_cnt <= 16'h0;
            if (step != 4'hE)
            begin
              step   <= step + 4'h1; // R20
              sstate <= S_RUN;
            end
            else if (mode == `MSS_MODE_CONT || mode == `MSS_MODE_CONT_SW)
            begin
              step   <= 4'h0; // R15
              sstate <= S_RUN;
            end
            else
            begin
              seq_running   <= 1'b0; // R14
              seq_prog_done <= 1'b1; // R13
              sstate        <= S_DONE;
            end
          end
          S_DONE:
            ; // left only by enable going low or mode set to off
          default:
            sstate <= S_IDLE;
        endcase
    end
  end

  // speed and direction command
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_cmd    <= 16'h0;
      dir_reverse <= 1'b0;
    end
    else if (sstate == S_RUN || sstate == S_NEXT)
    begin
      freq_cmd    <= step_freq[step]; // R11
      dir_reverse <= step_dir[step]; // R17
    end
    else
    begin
      freq_cmd    <= (sel_code == 4'h0) ? master_freq
                                        : step_freq[sel_code - 4'h1]; // R1
      dir_reverse <= din[`MSS_IN_DIR];
    end
  end

  // simple index positioning
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      istate      <= I_IDLE;
      prox_d      <= 1'b0;
      dec_cnt     <= 14'h0;
      idx_hold    <= 1'b0;
      idx_start   <= 1'b0;
      idx_decel   <= 1'b0;
      idx_stopped <= 1'b0;
    end
    else
    begin
      prox_d    <= din[`MSS_IN_PROX];
      idx_start <= 1'b0;
      case (istate)
        I_IDLE:
        begin
          idx_stopped <= 1'b0;
          if (idx_en && din[`MSS_IN_STOP])
          begin
            idx_hold <= 1'b1; // R7
            istate   <= I_WAIT;
          end
        end
        I_WAIT:
          if (din[`MSS_IN_PROX] && !prox_d) // R9
          begin
            idx_hold  <= 1'b0;
            idx_start <= 1'b1; // R8
            idx_decel <= 1'b1; // R7
            dec_cnt   <= 14'h0;
            istate    <= I_DEC;
          end
        I_DEC:
          if (dec_cnt >= idx_dec_time)
          begin
            idx_decel   <= 1'b0;
            idx_stopped <= 1'b1;
            istate      <= I_STOP;
          end
          else if (dec_tick)
            dec_cnt <= dec_cnt + 14'h1; // R6
        I_STOP:
          if (!din[`MSS_IN_STOP])
            istate <= I_IDLE;
        default:
          istate <= I_IDLE;
      endcase
    end
  end

endmodule // mss_top
`default_nettype wire

// File: test/mss_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mss_monitor
#(
  parameter DEB_UNIT_CYC  = 4,
  parameter STEP_UNIT_CYC = 20,
  parameter DEC_UNIT_CYC  = 10
)
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // speed and terminals
  input wire logic [15:0] freq_cmd,
  input wire logic        seq_running,
  input wire logic        seq_step_done,
  input wire logic        seq_prog_done,
  input wire logic        idx_start,
  input wire logic        idx_decel,
  input wire logic        idx_stopped
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property
    (psel && !penable |=> pready && psel && penable)
    else $error("no answer one cycle after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the access cycle");
  a_step_done_pulse: assert property
    (seq_step_done |=> !seq_step_done)
    else $error("step complete longer than one cycle");
  a_done_not_running: assert property
    (seq_prog_done |-> !seq_running)
    else $error("running while program complete");
  a_start_pulse_once: assert property (idx_start |=> !idx_start)
    else $error("index trigger longer than one cycle");
  a_decel_not_stopped: assert property
    (idx_decel |-> !idx_stopped)
    else $error("index decel and stopped together");
  a_freq_in_range: assert property (freq_cmd <= 16'h9C40)
    else $error("speed command above the top frequency");
endmodule // mss_monitor

bind mss_top mss_monitor #(
  .DEB_UNIT_CYC(DEB_UNIT_CYC),
  .STEP_UNIT_CYC(STEP_UNIT_CYC),
  .DEC_UNIT_CYC(DEC_UNIT_CYC)
) mss_monitor_inst (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .freq_cmd, .seq_running, .seq_step_done, .seq_prog_done,
  .idx_start, .idx_decel, .idx_stopped);
`default_nettype wire

// File: test/mss_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module mss_switch_model
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // requested contact levels
  input  wire logic [8:0] want,
  // levels at the terminals
  output var  logic [8:0] pins
);
  logic [8:0] last;
  logic [8:0] chg;
  logic [1:0] bc;
  // contacts chatter three cycles on each change, shorter than any
  // debounce interval, so a design that skips filtering sees glitches
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      last <= 9'h000;
      chg  <= 9'h000;
      bc   <= 2'h0;
      pins <= 9'h000;
    end
    else if (want !== last)
    begin
      chg  <= want ^ last;
      last <= want;
      bc   <= 2'h3;
      pins <= pins ^ (want ^ last);
    end
    else if (bc != 2'h0)
    begin
      bc   <= bc - 2'h1;
      pins <= (bc == 2'h1) ? last : pins ^ chg;
    end
endmodule // mss_switch_model
`default_nettype wire

// File: test/test_multistep_speed_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mss_consts.vh"
module test_multistep_speed_sequencer;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [8:0]  want;
  logic [3:0]  code;
  wire  [8:0]  pins;
  wire  [31:0] prdata;
  wire  [15:0] freq_cmd;
  wire         pready, pslverr, dir_reverse, seq_stepwise, seq_running;
  wire         seq_step_done, seq_prog_done, idx_hold, idx_start;
  wire         idx_decel, idx_stopped;
  integer      n_errors, checked, cyc, i;

  mss_top #(.DEB_UNIT_CYC(4), .STEP_UNIT_CYC(20), .DEC_UNIT_CYC(10))
  mss_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .speed_select_bit0(pins[0]),
    .speed_select_bit1(pins[1]), .speed_select_bit2(pins[2]),
    .speed_select_bit3(pins[3]), .seq_enable(pins[4]),
    .seq_pause(pins[5]), .prox_sensor(pins[6]), .stop_cmd(pins[7]),
    .dir_cmd_reverse(pins[8]), .freq_cmd, .dir_reverse, .seq_stepwise,
    .seq_running, .seq_step_done, .seq_prog_done, .idx_hold,
    .idx_start, .idx_decel, .idx_stopped);
  mss_switch_model mss_switch_model_inst (.pclk, .presetn, .want, .pins);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task conclude;
    begin
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      conclude;
    end
  end

  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task xfer(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n = n + 1;
      end
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rdchk(input [11:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(rd, e);
    end
  endtask

  function [15:0] obs(input [3:0] k);
    case (k)
      0: obs = {15'h0, seq_running};
      1: obs = {15'h0, seq_step_done};
      2: obs = {15'h0, seq_prog_done};
      3: obs = {15'h0, idx_hold};
      4: obs = {15'h0, idx_start};
      5: obs = {15'h0, idx_decel};
      6: obs = {15'h0, idx_stopped};
      7: obs = {15'h0, dir_reverse};
      default: obs = freq_cmd;
    endcase
  endfunction

  // waits a bounded time for an output, then compares it
  task wt(input [3:0] k, input [15:0] v, input integer n);
    integer c;
    begin
      c = 0;
      while (obs(k) !== v && c < n)
      begin
        @(posedge pclk);
        c = c + 1;
      end
      chk({16'h0, obs(k)}, {16'h0, v});
    end
  endtask

  function [15:0] ef(input [3:0] c);
    ef = (c == 4'h0) ? 16'h1234 : 16'h00FF + {12'h000, c};
  endfunction

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, err} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 9'h000;
    {n_errors, checked, cyc} = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`MSS_ADDR_DEB, 32'h1);
    rdchk(`MSS_ADDR_GEAR, 32'hC8);
    rdchk(`MSS_ADDR_ANGLE, 32'h708);
    rdchk(`MSS_ADDR_IDEC, 32'h0);
    rdchk(`MSS_ADDR_LAST - 12'h40, 32'h0);
    xfer(12'h020, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(`MSS_ADDR_GEAR, 1'b1, 32'h1);
    rdchk(`MSS_ADDR_GEAR, 32'h4);
    xfer(`MSS_ADDR_GEAR, 1'b1, 32'h3E9);
    rdchk(`MSS_ADDR_GEAR, 32'h3E8);
    xfer(`MSS_ADDR_ANGLE, 1'b1, 32'hE11);
    rdchk(`MSS_ADDR_ANGLE, 32'hE10);
    xfer(`MSS_ADDR_IDEC, 1'b1, 32'hFFFF);
    rdchk(`MSS_ADDR_IDEC, 32'h2710);
    xfer(`MSS_ADDR_FREQ0, 1'b1, 32'hFFFF);
    rdchk(`MSS_ADDR_FREQ0, 32'h9C40);
    xfer(`MSS_ADDR_DEB, 1'b1, 32'h0);
    rdchk(`MSS_ADDR_DEB, 32'h1);
    xfer(`MSS_ADDR_DEB, 1'b1, 32'h3);
    rdchk(`MSS_ADDR_DEB, 32'h3);
    for (i = 0; i < 6; i = i + 1)
    begin
      xfer(`MSS_ADDR_CTRL, 1'b1, i[31:0]);
      rdchk(`MSS_ADDR_CTRL, (i < 5) ? i[31:0] : 32'h0);
      chk({31'h0, seq_stepwise}, {31'h0, i == 3 || i == 4});
    end
    $display("test registers done");
    xfer(`MSS_ADDR_MASTER, 1'b1, 32'h1234);
    for (i = 0; i < 15; i = i + 1)
      xfer(`MSS_ADDR_FREQ0 + 4 * i[11:0], 1'b1, 32'hFF + i + 1);
    want[0] <= 1'b1;
    repeat (3) @(posedge pclk);
    want[0] <= 1'b0;
    repeat (40) @(posedge pclk);
    chk({16'h0, freq_cmd}, 32'h1234);
    for (i = 1; i < 17; i = i + 1)
    begin
      code = i[3:0];
      want[3:0] <= code;
      repeat (6) @(posedge pclk);
      chk({16'h0, freq_cmd}, {16'h0, ef(code - 4'h1)});
      wt(4'hF, ef(code), 60);
    end
    $display("test select done");
    for (i = 0; i < 15; i = i + 1)
      xfer(`MSS_ADDR_TIME0 + 4 * i[11:0], 1'b1,
           (i == 0) ? 32'h1 : (i == 2) ? 32'h5 : 32'h0);
    xfer(`MSS_ADDR_DIR, 1'b1, 32'h4);
    xfer(`MSS_ADDR_CTRL, 1'b1, 32'h1);
    want[4] <= 1'b1;
    wt(0, 16'h1, 60);
    wt(4'hF, 16'h100, 3);
    chk({31'h0, dir_reverse}, 32'h0);
    wt(1, 16'h1, 40);
    wt(4'hF, 16'h102, 10);
    wt(7, 16'h1, 3);
    wt(2, 16'h1, 140);
    repeat (60) @(posedge pclk);
    chk({31'h0, seq_running}, 32'h0);
    want[4] <= 1'b0;
    wt(2, 16'h0, 60);
    $display("test one_cycle done");
    xfer(`MSS_ADDR_CTRL, 1'b1, 32'h2);
    want[4] <= 1'b1;
    wt(4'hF, 16'h102, 60);
    want[5] <= 1'b1;
    repeat (240) @(posedge pclk);
    chk({16'h0, freq_cmd}, 32'h102);
    want[5] <= 1'b0;
    wt(4'hF, 16'h100, 200);
    chk({31'h0, seq_running}, 32'h1);
    want[4] <= 1'b0;
    wt(0, 16'h0, 40);
    $display("test continuous done");
    xfer(`MSS_ADDR_IDEC, 1'b1, 32'h2);
    xfer(`MSS_ADDR_CTRL, 1'b1, 32'h100);
    want[7] <= 1'b1;
    wt(3, 16'h1, 60);
    repeat (20) @(posedge pclk);
    chk({31'h0, idx_decel}, 32'h0);
    want[6] <= 1'b1;
    wt(4, 16'h1, 60);
    wt(5, 16'h1, 3);
    wt(6, 16'h1, 40);
    want[7] <= 1'b0;
    want[6] <= 1'b0;
    wt(6, 16'h0, 60);
    $display("test index done");
    conclude;
  end
endmodule // test_multistep_speed_sequencer
`default_nettype wire
